// ==== mebp_pkg.sv ====
`default_nettype none
// ==========================================================
// shared constants and carriers
package mebp_pkg;
	// ======================================================
	// machine cycle timing
	localparam int MEBP_OSC_PER_MC = 12;
	localparam int MEBP_RST_MC = 2;
	localparam int MEBP_RST_CLKS = MEBP_RST_MC * MEBP_OSC_PER_MC;
	localparam int MEBP_RQ_CW = 8;
	localparam logic [3:0] MEBP_PH_LAST = 4'hb;
	localparam logic [3:0] MEBP_PH_ALE0 = 4'h0;
	localparam logic [3:0] MEBP_PH_ALE1 = 4'h6;
	localparam logic [3:0] MEBP_ALE_LEN = 4'h2;
	localparam logic [3:0] MEBP_ADR_LEN = 4'h3;
	localparam logic [3:0] MEBP_PH_PSEN0 = 4'h3;
	localparam logic [3:0] MEBP_PH_PSEN1 = 4'h9;
	localparam logic [3:0] MEBP_PROGRAM_STORE_READ_STROBE_LEN = 4'h3;
	localparam logic [3:0] MEBP_PH_STB_ON = 4'h3;
	localparam logic [3:0] MEBP_PH_STB_OFF = 4'ha;
	localparam logic [3:0] MEBP_PH_RD_CAP = 4'ha;
	// ======================================================
	// register map
	localparam logic [7:0] MEBP_ADDR_STB_CTRL_OFS = 8'h8e;
	localparam int MEBP_ALE_DIS_BIT = 0;
	localparam logic [7:0] MEBP_ADDR_STB_CTRL_RST = 8'h00;
	localparam logic [7:0] MEBP_PORT_LATCH_OFS0 = 8'h80;
	localparam logic [7:0] MEBP_PORT_LATCH_STEP = 8'h10;
	localparam logic [7:0] MEBP_PORT_LATCH_RST = 8'hff;
	// ======================================================
	// pin positions
	localparam int MEBP_LOW_PORT = 0;
	localparam int MEBP_SECOND_PORT = 1;
	localparam int MEBP_HIGH_PORT = 2;
	localparam int MEBP_FOURTH_PORT = 3;
	localparam int MEBP_P1_T2 = 0;
	localparam int MEBP_P1_TIMER_TWO_TRIGGER_DIRECTION = 1;
	localparam int MEBP_P3_RX = 0;
	localparam int MEBP_P3_TX = 1;
	localparam int MEBP_P3_EXTERNAL_INTERRUPT_ZERO = 2;
	localparam int MEBP_P3_EXTERNAL_INTERRUPT_ONE = 3;
	localparam int MEBP_P3_TM0 = 4;
	localparam int MEBP_P3_TM1 = 5;
	localparam int MEBP_P3_WR = 6;
	localparam int MEBP_P3_RD = 7;
	// ======================================================
	// types
	typedef enum logic [1:0]
	{
		MEBP_K_INT = 2'b00,
		MEBP_K_FETCH = 2'b01,
		MEBP_K_XRD = 2'b10,
		MEBP_K_XWR = 2'b11
	} mebp_kind_t;
	typedef struct packed
	{
		logic xreq;
		logic write;
		logic wide;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mebp_bus_req_t;
	typedef struct packed
	{
		logic idle;
		logic power_down;
		logic move_or_table;
		logic lock_programmed;
	} mebp_mode_t;
	typedef struct packed
	{
		logic serial_tx;
		logic clock_out;
		logic clock_out_en;
	} mebp_alt_out_t;
	typedef struct packed
	{
		logic serial_rx;
		logic external_interrupt_zero;
		logic external_interrupt_one;
		logic timer_zero_input;
		logic timer_one_input;
		logic timer_two_count_input;
		logic timer_two_trigger_direction;
	} mebp_alt_in_t;
	typedef struct packed
	{
		logic [MEBP_RQ_CW-1:0] cnt;
		logic rst;
	} mebp_rq_st_t;
	typedef struct packed
	{
		logic [3:0] ph;
		mebp_kind_t kind;
		logic wide;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic ale_dis;
		logic [3:0][7:0] latch;
		logic ea_ext;
		logic once;
		logic once_arm;
		logic prev_rst;
		logic [3:0][7:0] p_out;
		logic [3:0][7:0] p_oe_n;
		logic ale_out;
		logic ale_oe_n;
		logic ale_weak;
		logic program_store_read_strobe_out;
		logic program_store_read_strobe_oe_n;
		logic program_store_read_strobe_weak;
		logic [7:0] sfr_rdata;
		logic bus_taken;
		logic bus_ack;
		logic [7:0] bus_rdata;
		logic code_valid;
		logic [7:0] code_byte;
		mebp_alt_in_t alt_in;
		logic core_rst;
		logic once_mode;
	} mebp_st_t;
endpackage
`default_nettype wire

// ==== mebp_rst_qual.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// reset pin qualifier: high for a full hold count
module mebp_rst_qual
	import mebp_pkg::*;
#(
	parameter int HOLD = MEBP_RST_CLKS
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reset_pin,
	output logic o_dev_rst
);
	mebp_rq_st_t s_q;
	mebp_rq_st_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (!i_reset_pin)
		begin
			s_d.cnt = '0;
			s_d.rst = 1'b0;
		end
		else if (s_q.cnt >= MEBP_RQ_CW'(HOLD - 1))
		begin
			s_d.rst = 1'b1;
		end
		else
		begin
			s_d.cnt = s_q.cnt + MEBP_RQ_CW'(1);
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			s_q.cnt <= '0;
			s_q.rst <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign o_dev_rst = s_q.rst;
endmodule
`default_nettype wire

// ==== mebp_top.sv ====
// Contract
// - low port is open drain; a latch one floats the pin for input
// - bus cycles put low address then data on low port, ones driven strongly
// - other ports are quasi-bidirectional; latch one pulls high, readable
// - second port bit 0 timer two count/clock out, bit 1 trigger/direction
// - high port drives high address on fetches and 16-bit data accesses
// - 8-bit indirect data accesses keep high port on its latch
// - fourth port bits carry serial, interrupts, timers and data strobes
// - reset pin high for two machine cycles resets the device
// - reset pin high forces all port pins to reset state at once
// - address strobe pulses at one sixth of the oscillator rate
// - one address strobe pulse is skipped per external data access
// - control bit 0 stops address strobe and leaves the pin weakly high
// - disable suspended in data move, table read, idle, power down, emulation
// - device reset clears the address strobe disable
// - disable has no effect while executing from external program memory
// - program strobe twice per machine cycle, both skipped in data access
// - with lock bits programmed the access strap is latched at reset
// - separate 64K program and data spaces with 16-bit addresses
// - strobe low in reset with program strobe high enters emulation mode
`timescale 1ns/1ps
`default_nettype none
module mebp_top
	import mebp_pkg::*;
#(
	parameter int RST_HOLD = MEBP_RST_CLKS
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reset_pin,
	input wire logic i_ext_access_strap_n,
	input wire mebp_mode_t i_mode,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire mebp_bus_req_t i_bus_req,
	input wire logic [15:0] i_fetch_addr,
	input wire mebp_alt_out_t i_alt_out,
	input wire logic [3:0][7:0] i_port_in,
	input wire logic i_ale_in,
	input wire logic i_program_store_read_strobe_in,
	output logic [3:0][7:0] o_port_out,
	output logic [3:0][7:0] o_port_oe_n,
	output logic o_ale_out,
	output logic o_ale_oe_n,
	output logic o_ale_weak_pull,
	output logic o_program_store_read_strobe_n_out,
	output logic o_program_store_read_strobe_oe_n,
	output logic o_program_store_read_strobe_weak_pull,
	output logic [7:0] o_sfr_rdata,
	output logic o_bus_taken,
	output logic o_bus_ack,
	output logic [7:0] o_bus_rdata,
	output logic o_code_valid,
	output logic [7:0] o_code_byte,
	output mebp_alt_in_t o_alt_in,
	output logic o_core_rst,
	output logic o_once_mode
);
	mebp_st_t s_q;
	mebp_st_t s_d;
	logic dev_rst;

	// ======================================================
	// reset qualification
	mebp_rst_qual #(.HOLD(RST_HOLD)) u_rst_qual
	(
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_reset_pin(i_reset_pin),
		.o_dev_rst(dev_rst)
	);

	// ======================================================
	// next state
	always_comb
	begin
		logic [3:0][7:0] eff;
		logic xfer;
		logic ale_pulse;
		logic ale_off;
		logic stb_low;
		logic adr_ph;
		logic [7:0] ofs;
		eff = '0;
		xfer = 1'b0;
		ale_pulse = 1'b0;
		ale_off = 1'b0;
		stb_low = 1'b0;
		adr_ph = 1'b0;
		ofs = '0;
		s_d = s_q;
		s_d.bus_taken = 1'b0;
		s_d.bus_ack = 1'b0;
		s_d.code_valid = 1'b0;
		xfer = (s_q.kind == MEBP_K_XRD) || (s_q.kind == MEBP_K_XWR);
		// phase counter
		s_d.ph = (s_q.ph == MEBP_PH_LAST) ? 4'h0 : s_q.ph + 4'h1;
		if (s_q.ph == MEBP_PH_LAST)
		begin
			if (i_bus_req.xreq && !dev_rst && !i_mode.idle && !i_mode.power_down)
			begin
				s_d.kind = i_bus_req.write ? MEBP_K_XWR : MEBP_K_XRD;
				s_d.addr = i_bus_req.addr;
				s_d.wide = i_bus_req.wide;
				s_d.wdata = i_bus_req.wdata;
				s_d.bus_taken = 1'b1;
			end
			else
			begin
				s_d.kind = s_q.ea_ext ? MEBP_K_FETCH : MEBP_K_INT;
				s_d.addr = i_fetch_addr;
				s_d.wide = 1'b1;
			end
		end
		if ((s_q.ph == MEBP_PH_ALE1 - 4'h1) && (s_q.kind == MEBP_K_FETCH))
		begin
			s_d.addr = i_fetch_addr;
		end
		// captures from the pins
		if ((s_q.kind == MEBP_K_FETCH) && ((s_q.ph == MEBP_PH_PSEN0 + MEBP_PROGRAM_STORE_READ_STROBE_LEN - 4'h1)
			|| (s_q.ph == MEBP_PH_PSEN1 + MEBP_PROGRAM_STORE_READ_STROBE_LEN - 4'h1)))
		begin
			s_d.code_valid = 1'b1;
			s_d.code_byte = i_port_in[MEBP_LOW_PORT];
		end
		if ((s_q.kind == MEBP_K_XRD) && (s_q.ph == MEBP_PH_RD_CAP))
		begin
			s_d.bus_rdata = i_port_in[MEBP_LOW_PORT];
		end
		if (xfer && (s_q.ph == MEBP_PH_LAST))
		begin
			s_d.bus_ack = 1'b1;
		end
		// special-function register port
		if (i_sfr_wr && !dev_rst)
		begin
			if (i_sfr_addr == MEBP_ADDR_STB_CTRL_OFS)
			begin
				s_d.ale_dis = i_sfr_wdata[MEBP_ALE_DIS_BIT];
			end
			for (int i = 0; i < 4; i++)
			begin
				ofs = MEBP_PORT_LATCH_OFS0 + 8'(i * MEBP_PORT_LATCH_STEP);
				if (i_sfr_addr == ofs)
				begin
					s_d.latch[i] = i_sfr_wdata;
				end
			end
		end
		s_d.sfr_rdata = 8'h00;
		if (i_sfr_addr == MEBP_ADDR_STB_CTRL_OFS)
		begin
			s_d.sfr_rdata[MEBP_ALE_DIS_BIT] = s_q.ale_dis;
		end
		for (int i = 0; i < 4; i++)
		begin
			ofs = MEBP_PORT_LATCH_OFS0 + 8'(i * MEBP_PORT_LATCH_STEP);
			if (i_sfr_addr == ofs)
			begin
				s_d.sfr_rdata = s_q.latch[i];
			end
		end
		// access strap, frozen after reset when locked
		if (!i_mode.lock_programmed || dev_rst)
		begin
			s_d.ea_ext = !i_ext_access_strap_n;
		end
		// emulation entry
		s_d.prev_rst = dev_rst;
		if (dev_rst)
		begin
			s_d.once = 1'b0;
			s_d.once_arm = s_q.once_arm || (!i_ale_in && i_program_store_read_strobe_in);
		end
		else
		begin
			s_d.once_arm = 1'b0;
			if (s_q.prev_rst)
			begin
				s_d.once = s_q.once_arm && !i_ale_in;
			end
		end
		// device reset
		if (dev_rst)
		begin
			s_d.ph = 4'h0;
			s_d.kind = MEBP_K_INT;
			s_d.ale_dis = MEBP_ADDR_STB_CTRL_RST[MEBP_ALE_DIS_BIT];
			s_d.latch = {4{MEBP_PORT_LATCH_RST}};
		end
		// port pins from latches and alternate functions
		eff = s_q.latch;
		if (i_alt_out.clock_out_en)
		begin
			eff[MEBP_SECOND_PORT][MEBP_P1_T2] = s_q.latch[MEBP_SECOND_PORT][MEBP_P1_T2]
				& i_alt_out.clock_out;
		end
		eff[MEBP_FOURTH_PORT][MEBP_P3_TX] = s_q.latch[MEBP_FOURTH_PORT][MEBP_P3_TX]
			& i_alt_out.serial_tx;
		stb_low = xfer && (s_q.ph >= MEBP_PH_STB_ON) && (s_q.ph <= MEBP_PH_STB_OFF);
		if (stb_low && (s_q.kind == MEBP_K_XWR))
		begin
			eff[MEBP_FOURTH_PORT][MEBP_P3_WR] = 1'b0;
		end
		if (stb_low && (s_q.kind == MEBP_K_XRD))
		begin
			eff[MEBP_FOURTH_PORT][MEBP_P3_RD] = 1'b0;
		end
		s_d.p_out = eff;
		s_d.p_oe_n = eff;
		// multiplexed bus on low and high ports
		adr_ph = (s_q.ph < MEBP_PH_ALE0 + MEBP_ADR_LEN)
			|| ((s_q.kind == MEBP_K_FETCH) && (s_q.ph >= MEBP_PH_ALE1)
			&& (s_q.ph < MEBP_PH_ALE1 + MEBP_ADR_LEN));
		if (s_q.kind != MEBP_K_INT)
		begin
			if (adr_ph)
			begin
				s_d.p_out[MEBP_LOW_PORT] = s_q.addr[7:0];
				s_d.p_oe_n[MEBP_LOW_PORT] = 8'h00;
			end
			else if (s_q.kind == MEBP_K_XWR)
			begin
				s_d.p_out[MEBP_LOW_PORT] = s_q.wdata;
				s_d.p_oe_n[MEBP_LOW_PORT] = 8'h00;
			end
			else
			begin
				s_d.p_out[MEBP_LOW_PORT] = 8'hff;
				s_d.p_oe_n[MEBP_LOW_PORT] = 8'hff;
			end
			if (s_q.wide)
			begin
				s_d.p_out[MEBP_HIGH_PORT] = s_q.addr[15:8];
				s_d.p_oe_n[MEBP_HIGH_PORT] = 8'h00;
			end
			else
			begin
				s_d.p_out[MEBP_HIGH_PORT] = eff[MEBP_HIGH_PORT];
				s_d.p_oe_n[MEBP_HIGH_PORT] = eff[MEBP_HIGH_PORT];
			end
		end
		// address latch strobe
		ale_pulse = ((s_q.ph >= MEBP_PH_ALE0) && (s_q.ph < MEBP_PH_ALE0 + MEBP_ALE_LEN))
			|| (!xfer && (s_q.ph >= MEBP_PH_ALE1)
			&& (s_q.ph < MEBP_PH_ALE1 + MEBP_ALE_LEN));
		ale_off = s_q.ale_dis && !s_q.ea_ext
			&& !i_mode.move_or_table && !i_mode.idle
			&& !i_mode.power_down && !s_q.once;
		s_d.ale_out = ale_pulse;
		s_d.ale_oe_n = 1'b0;
		s_d.ale_weak = 1'b0;
		if (ale_off)
		begin
			s_d.ale_out = 1'b1;
			s_d.ale_oe_n = 1'b1;
			s_d.ale_weak = 1'b1;
		end
		// program store read strobe
		s_d.program_store_read_strobe_out = !((s_q.kind == MEBP_K_FETCH)
			&& (((s_q.ph >= MEBP_PH_PSEN0) && (s_q.ph < MEBP_PH_PSEN0 + MEBP_PROGRAM_STORE_READ_STROBE_LEN))
			|| ((s_q.ph >= MEBP_PH_PSEN1) && (s_q.ph < MEBP_PH_PSEN1 + MEBP_PROGRAM_STORE_READ_STROBE_LEN))));
		s_d.program_store_read_strobe_oe_n = 1'b0;
		s_d.program_store_read_strobe_weak = 1'b0;
		// idle and power down hold the strobes
		if (i_mode.idle || i_mode.power_down)
		begin
			s_d.ale_out = i_mode.idle;
			s_d.ale_oe_n = 1'b0;
			s_d.ale_weak = 1'b0;
			s_d.program_store_read_strobe_out = i_mode.idle;
			if (s_q.ea_ext)
			begin
				s_d.p_out[MEBP_LOW_PORT] = 8'hff;
				s_d.p_oe_n[MEBP_LOW_PORT] = 8'hff;
			end
		end
		// emulation: low port floats, the rest weakly high
		if (s_q.once)
		begin
			s_d.p_out = {4{8'hff}};
			s_d.p_oe_n = {4{8'hff}};
			s_d.ale_out = 1'b1;
			s_d.ale_oe_n = 1'b1;
			s_d.ale_weak = 1'b1;
			s_d.program_store_read_strobe_out = 1'b1;
			s_d.program_store_read_strobe_oe_n = 1'b1;
			s_d.program_store_read_strobe_weak = 1'b1;
		end
		// reset pin forces pins at once
		if (i_reset_pin || dev_rst)
		begin
			s_d.p_out = {4{MEBP_PORT_LATCH_RST}};
			s_d.p_oe_n = {4{8'hff}};
			s_d.ale_out = 1'b1;
			s_d.ale_oe_n = 1'b1;
			s_d.ale_weak = 1'b1;
			s_d.program_store_read_strobe_out = 1'b1;
			s_d.program_store_read_strobe_oe_n = 1'b1;
			s_d.program_store_read_strobe_weak = 1'b1;
		end
		// alternate inputs
		s_d.alt_in.serial_rx = i_port_in[MEBP_FOURTH_PORT][MEBP_P3_RX];
		s_d.alt_in.external_interrupt_zero = i_port_in[MEBP_FOURTH_PORT][MEBP_P3_EXTERNAL_INTERRUPT_ZERO];
		s_d.alt_in.external_interrupt_one = i_port_in[MEBP_FOURTH_PORT][MEBP_P3_EXTERNAL_INTERRUPT_ONE];
		s_d.alt_in.timer_zero_input = i_port_in[MEBP_FOURTH_PORT][MEBP_P3_TM0];
		s_d.alt_in.timer_one_input = i_port_in[MEBP_FOURTH_PORT][MEBP_P3_TM1];
		s_d.alt_in.timer_two_count_input = i_port_in[MEBP_SECOND_PORT][MEBP_P1_T2];
		s_d.alt_in.timer_two_trigger_direction = i_port_in[MEBP_SECOND_PORT][MEBP_P1_TIMER_TWO_TRIGGER_DIRECTION];
		s_d.core_rst = dev_rst;
		s_d.once_mode = s_q.once;
	end

	// ======================================================
	// state register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			s_q <= '0;
			s_q.kind <= MEBP_K_INT;
			s_q.ale_dis <= MEBP_ADDR_STB_CTRL_RST[MEBP_ALE_DIS_BIT];
			s_q.latch <= {4{MEBP_PORT_LATCH_RST}};
			s_q.prev_rst <= 1'b1;
			s_q.p_out <= {4{MEBP_PORT_LATCH_RST}};
			s_q.p_oe_n <= {4{8'hff}};
			s_q.ale_out <= 1'b1;
			s_q.ale_oe_n <= 1'b1;
			s_q.ale_weak <= 1'b1;
			s_q.program_store_read_strobe_out <= 1'b1;
			s_q.program_store_read_strobe_oe_n <= 1'b1;
			s_q.program_store_read_strobe_weak <= 1'b1;
			s_q.alt_in <= '1;
			s_q.core_rst <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ======================================================
	// outputs
	assign o_port_out = s_q.p_out;
	assign o_port_oe_n = s_q.p_oe_n;
	assign o_ale_out = s_q.ale_out;
	assign o_ale_oe_n = s_q.ale_oe_n;
	assign o_ale_weak_pull = s_q.ale_weak;
	assign o_program_store_read_strobe_n_out = s_q.program_store_read_strobe_out;
	assign o_program_store_read_strobe_oe_n = s_q.program_store_read_strobe_oe_n;
	assign o_program_store_read_strobe_weak_pull = s_q.program_store_read_strobe_weak;
	assign o_sfr_rdata = s_q.sfr_rdata;
	assign o_bus_taken = s_q.bus_taken;
	assign o_bus_ack = s_q.bus_ack;
	assign o_bus_rdata = s_q.bus_rdata;
	assign o_code_valid = s_q.code_valid;
	assign o_code_byte = s_q.code_byte;
	assign o_alt_in = s_q.alt_in;
	assign o_core_rst = s_q.core_rst;
	assign o_once_mode = s_q.once_mode;
endmodule
`default_nettype wire

// ==== mebp_end.sv ====
`timescale 1ns/1ps

// ==== mebp_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// pin timing checks
module mebp_props
	import mebp_pkg::*;
#(
	parameter int RST_HOLD = MEBP_RST_CLKS
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reset_pin,
	input wire logic i_ext_access_strap_n,
	input wire mebp_mode_t i_mode,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire mebp_bus_req_t i_bus_req,
	input wire logic [3:0][7:0] o_port_out,
	input wire logic [3:0][7:0] o_port_oe_n,
	input wire logic o_ale_out,
	input wire logic o_ale_oe_n,
	input wire logic o_ale_weak_pull,
	input wire logic o_program_store_read_strobe_n_out,
	input wire logic o_bus_taken,
	input wire logic o_bus_ack,
	input wire logic o_code_valid,
	input wire logic o_core_rst
);
	logic off;
	logic [5:0] hi_q;
	assign off = !i_rst_n || i_reset_pin || o_core_rst;
	// consecutive high samples of the reset pin
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n || !i_reset_pin)
			hi_q <= 6'h00;
		else if (hi_q != 6'h3f)
			hi_q <= hi_q + 6'h01;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (off);
	// ====
	// assertions
	a_ale_rate: assert property (disable iff (off || o_ale_weak_pull)
		($rose(o_ale_out) && !o_bus_taken && !$past(o_bus_taken)) ##1 !o_bus_taken
		|-> ##5 $rose(o_ale_out)) else $error("strobe period wrong");
	a_ale_skip: assert property (o_bus_taken |-> ##2 (!$rose(o_ale_out))[*8])
		else $error("strobe not skipped");
	a_dis_weak: assert property (i_sfr_wr && i_sfr_addr == 8'h8e && i_sfr_wdata[0]
		&& i_ext_access_strap_n && i_mode == '0 |-> ##2 (o_ale_weak_pull && o_ale_oe_n))
		else $error("disable not applied");
	a_weak_susp: assert property ((i_mode.move_or_table || !i_ext_access_strap_n)[*2]
		|-> !o_ale_weak_pull) else $error("weak pull not suspended");
	a_rst_hold: assert property (disable iff (!i_rst_n) hi_q >= RST_HOLD + 3 |-> o_core_rst)
		else $error("reset not qualified");
	a_pin_force: assert property (disable iff (!i_rst_n) i_reset_pin && $past(i_reset_pin)
		|-> &o_port_oe_n && &o_port_out) else $error("pins not forced");
	a_lo_addr: assert property (o_bus_taken |-> ##1 o_port_oe_n[0] == 8'h00
		&& o_port_out[0] == $past(i_bus_req.addr[7:0])) else $error("low address wrong");
	a_hi_addr: assert property (o_bus_taken && i_bus_req.wide |-> ##1 o_port_oe_n[2] == 8'h00
		&& o_port_out[2] == $past(i_bus_req.addr[15:8])) else $error("high address wrong");
	a_wr_strobe: assert property (o_bus_taken && i_bus_req.write |-> ##4 !o_port_out[3][6]
		&& !o_port_oe_n[3][6] && o_port_out[0] == $past(i_bus_req.wdata, 4))
		else $error("write cycle wrong");
	a_ack_time: assert property (o_bus_taken |-> ##[11:12] o_bus_ack)
		else $error("ack late");
	a_program_store_read_strobe_skip: assert property (o_bus_taken |-> ##1 o_program_store_read_strobe_n_out[*8])
		else $error("program strobe not skipped");
	c_write: cover property (o_bus_taken && i_bus_req.write);
	c_read: cover property (o_bus_taken && !i_bus_req.write);
	c_code: cover property (o_code_valid);
endmodule
bind mebp_top mebp_props #(.RST_HOLD(RST_HOLD)) u_props (.*);
`default_nettype wire

// ==== mebp_xmem.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// external memory with address latch
module mebp_xmem
	import mebp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic [3:0][7:0] i_port_out,
	input wire logic [3:0][7:0] i_port_oe_n,
	input wire logic [3:0][7:0] i_pull_lo,
	input wire logic i_ale,
	input wire logic i_program_store_read_strobe_n,
	output wire logic [3:0][7:0] o_pin
);
	logic [7:0] mem [0:65535];
	logic [7:0] lo_q;
	logic [7:0] last_q = 8'h00;
	logic [15:0] a;
	logic [7:0] fl;
	assign a = {o_pin[2], lo_q};
	// code and data kept in separate spaces
	assign fl = !i_program_store_read_strobe_n ? (a[7:0] ^ a[15:8] ^ 8'h5a) :
		!o_pin[3][7] ? mem[a] : ~last_q & ~i_pull_lo[0];
	assign o_pin[0] = (i_port_out[0] & ~i_port_oe_n[0]) | (fl & i_port_oe_n[0]);
	assign o_pin[3:1] = (i_port_out[3:1] & ~i_port_oe_n[3:1]) | (~i_pull_lo[3:1] & i_port_oe_n[3:1]);
	always_ff @(posedge i_core_clk)
	begin
		if (i_ale)
			lo_q <= o_pin[0];
		if (!o_pin[3][6])
			mem[a] <= o_pin[0];
		last_q <= o_pin[0];
	end
endmodule
`default_nettype wire

// ==== mebp_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// pin level bench
module mebp_top_test
	import mebp_pkg::*;
;
	logic i_core_clk, i_rst_n, i_reset_pin, i_ext_access_strap_n, i_sfr_wr, ale_lo;
	mebp_mode_t i_mode;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_bus_rdata, o_code_byte, q;
	mebp_bus_req_t i_bus_req;
	logic [15:0] i_fetch_addr;
	mebp_alt_out_t i_alt_out;
	mebp_alt_in_t o_alt_in;
	wire logic [3:0][7:0] i_port_in;
	logic [3:0][7:0] o_port_out, o_port_oe_n, pull;
	logic i_ale_in, i_program_store_read_strobe_in, o_ale_out, o_ale_oe_n, o_ale_weak_pull;
	logic o_program_store_read_strobe_n_out, o_program_store_read_strobe_oe_n;
	logic o_program_store_read_strobe_weak_pull, o_bus_taken, o_bus_ack;
	logic o_code_valid, o_core_rst, o_once_mode;
	logic [3:0] ev;
	int c, miscompares, checks_done;
	assign ev = {o_ale_out, o_code_valid, o_bus_ack, o_bus_taken};
	assign i_ale_in = o_ale_oe_n ? !ale_lo : o_ale_out;
	assign i_program_store_read_strobe_in = o_program_store_read_strobe_oe_n
		|| o_program_store_read_strobe_n_out;
	mebp_top u_dut (.*);
	mebp_xmem u_mem (.i_core_clk(i_core_clk), .i_port_out(o_port_out), .i_port_oe_n(o_port_oe_n),
		.i_pull_lo(pull), .i_ale(i_ale_in), .i_program_store_read_strobe_n(i_program_store_read_strobe_in),
		.o_pin(i_port_in));
	always #5 i_core_clk = ~i_core_clk;
	// ====
	// tasks
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		tick(1);
		i_sfr_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_sfr_addr = a;
		tick(2);
		chk("sfr", o_sfr_rdata, e);
	endtask
	task automatic until_hi(input int k);
		int n;
		n = 0;
		while (ev[k] !== 1'b1)
		begin
			tick(1);
			n++;
			if (n > 60)
			begin
				miscompares++;
				print_verdict();
			end
		end
	endtask
	task automatic rises(input int k, input int n);
		logic p;
		c = 0;
		p = ev[k];
		repeat (n)
		begin
			tick(1);
			if (ev[k] && !p)
				c++;
			p = ev[k];
		end
	endtask
	task automatic xfer(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
		i_bus_req = {1'b1, w, wd, a, d};
		until_hi(0);
		i_bus_req.xreq = 1'b0;
		tick(1);
		until_hi(1);
		q = o_bus_rdata;
	endtask
	task automatic hard_rst();
		i_reset_pin = 1'b1;
		tick(30);
		chk("core_rst", o_core_rst, 1);
		i_mode = '0;
		i_reset_pin = 1'b0;
		tick(4);
	endtask
	// ====
	// sequence
	initial
	begin
		{i_core_clk, i_rst_n, i_reset_pin, i_sfr_wr, ale_lo, i_mode, i_alt_out} = '0;
		{i_sfr_addr, i_sfr_wdata, i_bus_req, pull, c, miscompares, checks_done} = '0;
		i_ext_access_strap_n = 1'b1;
		i_fetch_addr = 16'h0abc;
		tick(12);
		i_rst_n = 1'b1;
		tick(3);
		chk("core_rst", o_core_rst, 0);
		rd(8'h8e, 8'h00);
		rd(8'h01, 8'h00);
		wr(8'h80, 8'h0f);
		wr(8'h90, 8'ha7);
		pull[3] = 8'h15;
		i_alt_out = 3'b001;
		tick(3);
		chk("p0_oe", o_port_oe_n[0], 8'h0f);
		chk("p1_oe", o_port_oe_n[1][7:1], 7'h53);
		chk("t2", {o_alt_in.timer_two_count_input, o_alt_in.timer_two_trigger_direction}, 2'b01);
		chk("p3_in", {o_alt_in.serial_rx, o_alt_in.external_interrupt_zero, o_alt_in.external_interrupt_one,
			o_alt_in.timer_zero_input, o_alt_in.timer_one_input}, 5'b00101);
		chk("tx", o_port_out[3][1], 0);
		i_alt_out = 3'b011;
		tick(3);
		chk("clk_out", o_port_out[1][0], 1);
		pull = '0;
		wr(8'ha0, 8'h77);
		xfer(1, 1, 16'h1234, 8'h3c);
		xfer(1, 0, 16'h0056, 8'hc3);
		xfer(0, 1, 16'h1234, 8'h00);
		chk("rd_wide", q, 8'h3c);
		xfer(0, 0, 16'h0056, 8'h00);
		chk("rd_narrow", q, 8'hc3);
		chk("mem", u_mem.mem[16'h7756], 8'hc3);
		rises(3, 48);
		chk("ale_rate", 16'(c), 8);
		wr(8'h8e, 8'h01);
		tick(2);
		chk("weak", o_ale_weak_pull, 1);
		rd(8'h8e, 8'h01);
		rises(3, 24);
		chk("ale_off", 16'(c), 0);
		i_mode.move_or_table = 1'b1;
		tick(1);
		rises(3, 24);
		chk("ale_susp", 16'(c), 4);
		i_ext_access_strap_n = 1'b0;
		tick(3);
		i_mode.move_or_table = 1'b0;
		rises(3, 48);
		chk("ale_ext", 16'(c), 8);
		rises(2, 48);
		chk("fetches", 16'(c), 8);
		xfer(1, 1, 16'h0abc, 8'h11);
		until_hi(2);
		chk("code", o_code_byte, 8'h5a ^ 8'h0a ^ 8'hbc);
		i_ext_access_strap_n = 1'b1;
		wr(8'h90, 8'h3c);
		i_reset_pin = 1'b1;
		tick(10);
		chk("force", {&o_port_oe_n, &o_port_out}, 2'b11);
		chk("short", o_core_rst, 0);
		i_reset_pin = 1'b0;
		tick(4);
		rd(8'h90, 8'h3c);
		hard_rst();
		rd(8'h8e, 8'h00);
		chk("weak_rst", o_ale_weak_pull, 0);
		i_mode.power_down = 1'b1;
		tick(3);
		chk("pd", {o_ale_out, o_program_store_read_strobe_n_out, o_ale_weak_pull}, 3'b000);
		ale_lo = 1'b1;
		hard_rst();
		ale_lo = 1'b0;
		tick(2);
		chk("once", {o_once_mode, o_port_oe_n[0], o_program_store_read_strobe_oe_n,
			o_program_store_read_strobe_weak_pull}, 11'h7ff);
		hard_rst();
		chk("once_off", o_once_mode, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
